// ===== src/qduc_pkg.sv
// constants, field positions and reset values for the quad converter update control
// assumes one system clock; both ends import this package
package qduc_pkg;
  localparam int QD_WORD_W = 24;
  localparam int QD_DATA_W = 16;
  localparam int QD_NCH = 4;
  localparam int QD_RW_BIT = 23;
  localparam int QD_ADDR_LSB = 16;
  localparam logic [4:0] QD_MIN_FALLS = 5'h18;
  localparam logic [4:0] QD_CNT_MAX = 5'h1f;
  localparam logic [3:0] QD_A_CMD = 4'h0;
  localparam logic [3:0] QD_A_MON = 4'h1;
  localparam logic [1:0] QD_G_CTL = 2'h0;
  localparam logic [1:0] QD_G_DAC = 2'h1;
  localparam logic [1:0] QD_G_ZERO = 2'h2;
  localparam logic [1:0] QD_G_GAIN = 2'h3;
  localparam int QD_C_AB = 15;
  localparam int QD_C_LD = 14;
  localparam int QD_C_RST = 13;
  localparam int QD_C_PDA = 12;
  localparam int QD_C_PDB = 11;
  localparam int QD_C_GPIO = 8;
  localparam int QD_C_DSDO = 7;
  localparam int QD_C_NOP = 6;
  localparam int QD_C_GAIN = 2;
  localparam int QD_MON_LSB = 11;
  localparam int QD_ZERO_W = 9;
  localparam int QD_GCAL_W = 8;
  localparam logic [15:0] QD_CODE_RST = 16'h0000;
  localparam logic [15:0] QD_BIP_FLIP = 16'h8000;
  localparam logic [3:0] QD_GAIN_RST = 4'hf;
  localparam logic [1:0] QD_GPIO_RST = 2'h3;
  localparam int QD_CLK_KHZ = 25000;
  localparam int QD_WAKE_NS = 50000;
  localparam int QD_WAKE_CYC = (QD_WAKE_NS * QD_CLK_KHZ + 999999) / 1000000;
  localparam int QD_WAKE_W = 11;
  // host controller register map, byte addresses
  localparam logic [7:0] QD_H_TXD = 8'h00;
  localparam logic [7:0] QD_H_RXD = 8'h04;
  localparam logic [7:0] QD_H_STAT = 8'h08;
  localparam logic [7:0] QD_H_PINS = 8'h0c;
  localparam logic [1:0] QD_PINS_RST = 2'h3;
  localparam logic [1:0] QD_RESP_OK = 2'h0;
  localparam logic [1:0] QD_RESP_ERR = 2'h2;
  localparam int QD_SCLK_HALF = 4;
endpackage : qduc_pkg

// ===== src/qduc_link_if.sv
// serial link between host controller and converter control
// data line is pulled high when the device releases it
`timescale 1ns/10ps
interface qduc_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic load_strobe_n;
  logic reset_pin_n;
  logic sdo;
  logic sdo_oe_n;
  logic sdo_line;
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;
  modport dev (input sclk, cs_n, sdi, load_strobe_n, reset_pin_n, output sdo, sdo_oe_n);
  modport host (output sclk, cs_n, sdi, load_strobe_n, reset_pin_n, input sdo_line);
endinterface : qduc_link_if

// ===== src/qduc_dev.sv
// device end: serial register file, double-buffered codes, reset, monitor, power-down
// assumes link pins are asynchronous to clk; every pin passes two flops first
`timescale 1ns/10ps
module qduc_dev
  import qduc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // serial link
  qduc_link_if.dev link,
  // polarity straps
  input wire logic group_a_polarity_pin,
  input wire logic group_b_polarity_pin,
  // channel outputs
  output logic [3:0][15:0] chan_latch,
  output logic [3:0][15:0] chan_ladder_code,
  output logic [3:0] chan_unipolar,
  output logic [3:0] chan_gain_x4,
  output logic [3:0][8:0] chan_zero_code,
  output logic [3:0][7:0] chan_gain_code,
  // power-down and monitor
  output logic [1:0] group_powerdown,
  output logic [1:0] group_ready,
  output logic [4:0] monitor_output_sel,
  output logic monitor_output_hiz
);
  typedef struct packed {
    logic [23:0] shift;
    logic [4:0] falls;
    logic [23:0] out_sh;
    logic rd_pend;
    logic [3:0] rd_addr;
    logic ab;
    logic pd_a;
    logic pd_b;
    logic [1:0] gpio;
    logic dsdo;
    logic nop;
    logic [3:0] gain;
    logic [4:0] mon;
    logic [3:0][15:0] inreg;
    logic [3:0][15:0] latch;
    logic [3:0] dirty;
    logic [3:0][8:0] zero;
    logic [3:0][7:0] gcal;
    logic ld_pulse;
    logic soft_rst;
    logic [1:0][10:0] wake;
  } qduc_regs_s;

  typedef struct packed {
    logic [6:0] sy1;
    logic [6:0] sy2;
    logic sclk_q;
    logic cs_q;
    qduc_regs_s r;
    logic [3:0][15:0] ladder;
    logic [3:0] uni;
    logic [1:0] ready;
    logic [4:0] msel;
  } qduc_dev_s;

  localparam qduc_regs_s REG_RST = '{gain: QD_GAIN_RST, gpio: QD_GPIO_RST, default: '0};
  localparam qduc_dev_s DEV_RST = '{sy1: 7'h7f, sy2: 7'h7f, sclk_q: 1'b1, cs_q: 1'b1,
                                    r: REG_RST, ready: 2'h3, default: '0};

  qduc_dev_s s_r;
  qduc_dev_s s_nxt;

  logic sclk_s;
  logic cs_s;
  logic sdi_s;
  logic load_strobe_pin_s;
  logic rstp_s;
  logic [1:0] pol_s;
  logic [15:0] wdat;
  logic [3:0] waddr;
  logic [1:0] widx;
  logic ld_evt;
  logic [15:0] rdat;

  assign {sclk_s, cs_s, sdi_s, load_strobe_pin_s, rstp_s, pol_s} = s_r.sy2;
  assign wdat = s_r.r.shift[QD_DATA_W-1:0];
  assign waddr = s_r.r.shift[QD_ADDR_LSB+3:QD_ADDR_LSB];
  assign widx = waddr[1:0];

  // readback mux returns fields in their write positions
  always_comb begin
    rdat = '0;
    case (s_r.r.rd_addr[3:2])
      QD_G_CTL: begin
        if (s_r.r.rd_addr == QD_A_CMD) begin
          rdat[QD_C_AB] = s_r.r.ab;
          rdat[QD_C_PDA] = s_r.r.pd_a;
          rdat[QD_C_PDB] = s_r.r.pd_b;
          rdat[QD_C_GPIO+:2] = s_r.r.gpio;
          rdat[QD_C_DSDO] = s_r.r.dsdo;
          rdat[QD_C_NOP] = s_r.r.nop;
          rdat[QD_C_GAIN+:4] = s_r.r.gain;
        end else if (s_r.r.rd_addr == QD_A_MON) begin
          rdat[QD_MON_LSB+:5] = s_r.r.mon;
        end
      end
      QD_G_DAC: rdat = s_r.r.inreg[s_r.r.rd_addr[1:0]];
      QD_G_ZERO: rdat[QD_ZERO_W-1:0] = s_r.r.zero[s_r.r.rd_addr[1:0]];
      QD_G_GAIN: rdat[QD_GCAL_W-1:0] = s_r.r.gcal[s_r.r.rd_addr[1:0]];
      default: rdat = '0;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.sy1 = {link.sclk, link.cs_n, link.sdi, link.load_strobe_n, link.reset_pin_n,
                 group_b_polarity_pin, group_a_polarity_pin};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sclk_q = sclk_s;
    s_nxt.cs_q = cs_s;
    ld_evt = s_r.r.ld_pulse | ~load_strobe_pin_s;
    s_nxt.r.ld_pulse = 1'b0;
    s_nxt.r.soft_rst = 1'b0;
    if (!rstp_s || s_r.r.soft_rst) begin
      // link frozen and every register back to default
      s_nxt.r = REG_RST;
    end else begin
      // a new frame hands out the word picked by the last read
      if (s_r.cs_q && !cs_s) begin
        s_nxt.r.falls = '0;
        s_nxt.r.out_sh = s_r.r.rd_pend ? {4'h0, s_r.r.rd_addr, rdat} : '0;
        s_nxt.r.rd_pend = 1'b0;
      end
      if (!cs_s && s_r.sclk_q && !sclk_s) begin
        s_nxt.r.shift = {s_r.r.shift[QD_WORD_W-2:0], sdi_s};
        s_nxt.r.out_sh = {s_r.r.out_sh[QD_WORD_W-2:0], 1'b0};
        if (s_r.r.falls != QD_CNT_MAX) begin
          s_nxt.r.falls = s_r.r.falls + 5'h01;
        end
      end
      // latches reload only where the input register is fresh
      for (int i = 0; i < QD_NCH; i++) begin
        if (ld_evt && s_r.r.dirty[i]) begin
          s_nxt.r.latch[i] = s_r.r.inreg[i];
          s_nxt.r.dirty[i] = 1'b0;
        end
      end
      // short frames fall through without effect
      if (!s_r.cs_q && cs_s && s_r.r.falls >= QD_MIN_FALLS) begin
        if (s_r.r.shift[QD_RW_BIT]) begin
          s_nxt.r.rd_addr = waddr;
          s_nxt.r.rd_pend = 1'b1;
        end else begin
          case (waddr[3:2])
            QD_G_CTL: begin
              if (waddr == QD_A_CMD) begin
                s_nxt.r.ab = wdat[QD_C_AB];
                s_nxt.r.ld_pulse = wdat[QD_C_LD];
                s_nxt.r.soft_rst = wdat[QD_C_RST];
                s_nxt.r.pd_a = wdat[QD_C_PDA];
                s_nxt.r.pd_b = wdat[QD_C_PDB];
                s_nxt.r.gpio = wdat[QD_C_GPIO+:2];
                s_nxt.r.dsdo = wdat[QD_C_DSDO];
                s_nxt.r.nop = wdat[QD_C_NOP];
                s_nxt.r.gain = wdat[QD_C_GAIN+:4];
              end else if (waddr == QD_A_MON) begin
                s_nxt.r.mon = wdat[QD_MON_LSB+:5];
              end
            end
            QD_G_DAC: begin
              s_nxt.r.inreg[widx] = wdat;
              s_nxt.r.dirty[widx] = 1'b1;
            end
            QD_G_ZERO: s_nxt.r.zero[widx] = wdat[QD_ZERO_W-1:0];
            QD_G_GAIN: s_nxt.r.gcal[widx] = wdat[QD_GCAL_W-1:0];
            default: s_nxt.r = s_r.r;
          endcase
        end
      end
      // recovery timer restarts on every power-down
      for (int g = 0; g < 2; g++) begin
        if (g == 0 ? s_r.r.pd_a : s_r.r.pd_b) begin
          s_nxt.r.wake[g] = QD_WAKE_W'(QD_WAKE_CYC);
        end else if (s_r.r.wake[g] != '0) begin
          s_nxt.r.wake[g] = s_r.r.wake[g] - 11'h001;
        end
      end
    end
    // derived outputs, registered so data pins come from flops
    for (int i = 0; i < QD_NCH; i++) begin
      s_nxt.uni[i] = (i < 2) ? pol_s[0] : pol_s[1];
      s_nxt.ladder[i] = s_nxt.uni[i] ? s_nxt.r.latch[i] : s_nxt.r.latch[i] ^ QD_BIP_FLIP;
    end
    s_nxt.ready[0] = !s_nxt.r.pd_a && s_nxt.r.wake[0] == '0;
    s_nxt.ready[1] = !s_nxt.r.pd_b && s_nxt.r.wake[1] == '0;
    // lowest set source wins so two sources never short together
    s_nxt.msel = '0;
    for (int m = 4; m >= 0; m--) begin
      if (s_nxt.r.mon[m]) begin
        s_nxt.msel = 5'h01 << m;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= DEV_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // outputs hold latched codes until new ones are loaded or a pin or soft reset clears them
  assign chan_latch = s_r.r.latch;
  assign chan_ladder_code = s_r.ladder;
  assign chan_unipolar = s_r.uni;
  assign chan_gain_x4 = s_r.r.gain;
  assign chan_zero_code = s_r.r.zero;
  assign chan_gain_code = s_r.r.gcal;
  assign group_powerdown = {s_r.r.pd_b, s_r.r.pd_a};
  assign group_ready = s_r.ready;
  assign monitor_output_sel = {s_r.msel[0], s_r.msel[1], s_r.msel[2], s_r.msel[3], s_r.msel[4]};
  assign monitor_output_hiz = s_r.msel == '0;
  assign link.sdo = s_r.r.out_sh[QD_WORD_W-1];
  // link stays released while the reset pin holds the device
  assign link.sdo_oe_n = cs_s | s_r.r.dsdo | !rstp_s;
endmodule : qduc_dev

// ===== src/qduc_host.sv
// host end: AXI4-Lite register slave driving the serial link
// assumes sdo line comes from outside clk domain; sclk made here by divider
`timescale 1ns/10ps
module qduc_host
  import qduc_pkg::*;
#(
  parameter int HALF = QD_SCLK_HALF
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial link
  qduc_link_if.host link
);
  if (HALF < 4 || HALF > 127) begin : g_chk
    $error("HALF must be 4..127");
  end

  typedef enum logic [5:0] {
    H_IDLE = 6'b000001, H_LEAD = 6'b000010, H_LOW = 6'b000100,
    H_HIGH = 6'b001000, H_TAIL = 6'b010000, H_GAP = 6'b100000
  } qduc_hst_e;

  typedef struct packed {
    qduc_hst_e st;
    logic [7:0] div;
    logic [4:0] bits;
    logic [23:0] tx;
    logic [23:0] rx;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic [1:0] pins;
    logic [1:0] sy;
    logic aw_h;
    logic [7:0] awaddr;
    logic w_h;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } qduc_host_s;

  localparam qduc_host_s HOST_RST = '{st: H_IDLE, sclk: 1'b1, cs_n: 1'b1, pins: QD_PINS_RST,
                                      sy: 2'h3, default: '0};
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);
  localparam logic [7:0] FULL_M1 = 8'(2 * HALF - 1);
  localparam logic [4:0] LAST_BIT = 5'(QD_WORD_W - 1);

  qduc_host_s s_r;
  qduc_host_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sy = {s_r.sy[0], link.sdo_line};
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_h = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_h = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = QD_RESP_OK;
      case (s_axi_araddr)
        QD_H_TXD: s_nxt.rdata = {8'h00, s_r.tx};
        QD_H_RXD: s_nxt.rdata = {8'h00, s_r.rx};
        QD_H_STAT: s_nxt.rdata = {31'h0, s_r.st != H_IDLE};
        QD_H_PINS: s_nxt.rdata = {30'h0, s_r.pins};
        default: begin
          s_nxt.rdata = '0;
          s_nxt.rresp = QD_RESP_ERR;
        end
      endcase
    end
    if (s_r.div != '0) begin
      s_nxt.div = s_r.div - 8'h01;
    end
    case (s_r.st)
      H_IDLE: ;
      // first edge after select must be falling, so sclk idles high
      H_LEAD: if (s_r.div == '0) begin
        s_nxt.sclk = 1'b0;
        s_nxt.rx = {s_r.rx[22:0], s_r.sy[1]};
        s_nxt.div = HALF_M1;
        s_nxt.st = H_LOW;
      end
      H_LOW: if (s_r.div == '0) begin
        s_nxt.sclk = 1'b1;
        s_nxt.div = HALF_M1;
        s_nxt.bits = s_r.bits + 5'h01;
        s_nxt.tx = {s_r.tx[22:0], 1'b0};
        s_nxt.sdi = s_r.tx[22];
        s_nxt.st = (s_r.bits == LAST_BIT) ? H_TAIL : H_HIGH;
      end
      H_HIGH: if (s_r.div == '0) begin
        s_nxt.sclk = 1'b0;
        s_nxt.rx = {s_r.rx[22:0], s_r.sy[1]};
        s_nxt.div = HALF_M1;
        s_nxt.st = H_LOW;
      end
      H_TAIL: if (s_r.div == '0) begin
        s_nxt.cs_n = 1'b1;
        s_nxt.div = FULL_M1;
        s_nxt.st = H_GAP;
      end
      H_GAP: if (s_r.div == '0) begin
        s_nxt.st = H_IDLE;
      end
      default: s_nxt.st = H_IDLE;
    endcase
    if (s_r.aw_h && s_r.w_h && !s_r.bvalid) begin
      s_nxt.aw_h = 1'b0;
      s_nxt.w_h = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = QD_RESP_OK;
      case (s_r.awaddr)
        QD_H_TXD: if (s_r.st == H_IDLE && s_r.wstrb[2:0] == 3'h7) begin
          s_nxt.tx = s_r.wdata[23:0];
          s_nxt.sdi = s_r.wdata[23];
          s_nxt.cs_n = 1'b0;
          s_nxt.bits = '0;
          s_nxt.div = FULL_M1;
          s_nxt.st = H_LEAD;
        end
        QD_H_PINS: if (s_r.wstrb[0]) begin
          s_nxt.pins = s_r.wdata[1:0];
        end
        QD_H_RXD, QD_H_STAT: ;
        default: s_nxt.bresp = QD_RESP_ERR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= HOST_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = !s_r.aw_h && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_h && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign link.sclk = s_r.sclk;
  assign link.cs_n = s_r.cs_n;
  assign link.sdi = s_r.sdi;
  assign link.load_strobe_n = s_r.pins[0];
  assign link.reset_pin_n = s_r.pins[1];
endmodule : qduc_host

// ===== dv/qduc_monitor.sv
// link checker for the quad converter update control
// assumes the host end makes sclk with HALF = 4 and one clk domain
`timescale 1ns/10ps
module qduc_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic reset_pin_n,
  input wire logic sdo_oe_n
);
  logic sclk_r;
  logic [4:0] fall_cnt_r;

  // counts falling sclk edges inside one frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_r <= 1'b1;
      fall_cnt_r <= 5'h00;
    end else begin
      sclk_r <= sclk;
      if (cs_n) begin
        fall_cnt_r <= 5'h00;
      end else if (sclk_r && !sclk) begin
        fall_cnt_r <= fall_cnt_r + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("sclk low while deselected");
  a_sclk_in_frame: assert property (!sclk |-> !cs_n)
    else $error("select changed while sclk low");
  a_cs_fall_lead: assert property ($fell(cs_n) |-> sclk [*5])
    else $error("sclk fell too soon after select");
  a_sdi_held: assert property ($fell(sclk) |-> $stable(sdi))
    else $error("sdi moved at sampling edge");
  a_sclk_low_half: assert property ($fell(sclk) |-> (!sclk) [*4] ##1 sclk)
    else $error("sclk low phase length wrong");
  a_frame_24: assert property ($rose(cs_n) |-> fall_cnt_r == 5'h18)
    else $error("frame without 24 falling edges");
  a_sdo_released: assert property (cs_n [*5] |-> sdo_oe_n)
    else $error("sdo driven while deselected");
  a_reset_quiet: assert property ((!reset_pin_n) [*5] |-> sdo_oe_n)
    else $error("sdo driven during pin reset");
endmodule : qduc_monitor

// ===== dv/test_quad_dac_update_control.sv
// bench: host end and device end joined by the link, a second device end bit-banged
// assumes 25 MHz clk; link b carries deliberately broken frames
`timescale 1ns/10ps
module test_quad_dac_update_control
  import qduc_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pa = 1'b1;
  logic pb = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, hiz;
  logic [1:0] bresp, rresp, pd, rdy;
  logic [31:0] rdata;
  logic [3:0][15:0] latch, ladder, latch_b;
  logic [3:0] uni, gx4;
  logic [3:0][8:0] zc;
  logic [3:0][7:0] gc;
  logic [4:0] msel;
  int error_cnt = 0;
  int n_tests = 0;
  int wake_n = 0;
  qduc_link_if link();
  qduc_link_if link_b();

  always #20 clk = ~clk;
  // cycles since group a left power-down
  always @(posedge clk) wake_n <= pd[0] ? 0 : (rdy[0] ? wake_n : wake_n + 1);

  qduc_host u_qduc_host (.clk(clk), .nrst(nrst), .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.host));
  qduc_dev u_qduc_dev (.clk(clk), .nrst(nrst), .ce(1'b1), .link(link.dev), .group_a_polarity_pin(pa),
    .group_b_polarity_pin(pb), .chan_latch(latch), .chan_ladder_code(ladder), .chan_unipolar(uni),
    .chan_gain_x4(gx4), .chan_zero_code(zc), .chan_gain_code(gc), .group_powerdown(pd),
    .group_ready(rdy), .monitor_output_sel(msel), .monitor_output_hiz(hiz));
  qduc_dev u_qduc_dev_b (.clk(clk), .nrst(nrst), .ce(1'b1), .link(link_b.dev), .group_a_polarity_pin(pa),
    .group_b_polarity_pin(pb), .chan_latch(latch_b), .chan_ladder_code(), .chan_unipolar(),
    .chan_gain_x4(), .chan_zero_code(), .chan_gain_code(), .group_powerdown(), .group_ready(),
    .monitor_output_sel(), .monitor_output_hiz());
  qduc_monitor u_qduc_monitor (.clk(clk), .nrst(nrst), .sclk(link.sclk), .cs_n(link.cs_n), .sdi(link.sdi),
    .reset_pin_n(link.reset_pin_n), .sdo_oe_n(link.sdo_oe_n));

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task tmo;
    error_cnt++;
    $display("Error wait expected answer seen none");
    finish_test();
  endtask : tmo

  // ready and answer are sampled mid-cycle, so they hold the value seen at the next edge
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic sa, sw, sb;
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      sa = awready;
      sw = wready;
      sb = bvalid;
      r = bresp;
      @(posedge clk);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
      if (sb) break;
    end
    bready <= 1'b0;
    if (i == 100) tmo();
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic sa, sr;
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      sa = arready;
      sr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (sa) arvalid <= 1'b0;
      if (sr) break;
    end
    rready <= 1'b0;
    if (i == 100) tmo();
  endtask : axi_rd

  task frame(input logic [23:0] w);
    logic [31:0] s;
    logic [1:0] r;
    int i;
    axi_wr(QD_H_TXD, {8'h00, w}, r);
    for (i = 0; i < 300; i++) begin
      axi_rd(QD_H_STAT, s, r);
      if (s[0] === 1'b0) break;
    end
    if (i == 300) tmo();
    repeat (8) @(posedge clk);
  endtask : frame

  task wr(input logic [3:0] a, input logic [15:0] d);
    frame({4'h0, a, d});
  endtask : wr

  // n bits of w, msb first, on link b
  task bang(input logic [31:0] w, input int n);
    int i;
    link_b.cs_n <= 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      link_b.sdi <= w[i];
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'b0;
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    link_b.cs_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : bang

  task t_reset;
    logic [31:0] d;
    logic [1:0] r;
    chk("gain_x4", gx4, QD_GAIN_RST);
    chk("latch0", latch[0], QD_CODE_RST);
    chk("mon_hiz", hiz, 1'b1);
    axi_wr(8'h10, 32'h0, r);
    chk("bresp", r, QD_RESP_ERR);
    axi_rd(8'h10, d, r);
    chk("rresp", r, QD_RESP_ERR);
    chk("rdata", d, 32'h0);
    $display("reset and map test done");
  endtask : t_reset

  task t_defer;
    logic [1:0] r;
    axi_wr(QD_H_PINS, 32'h3, r);
    wr(4'h4, 16'h1234);
    chk("latch0 held", latch[0], 16'h0);
    wr(4'h0, 16'h403c);
    chk("latch0 load", latch[0], 16'h1234);
    chk("latch1 kept", latch[1], 16'h0);
    wr(4'h5, 16'h00aa);
    chk("latch1 no reload", latch[1], 16'h0);
    $display("deferred load test done");
  endtask : t_defer

  task t_indiv;
    logic [1:0] r;
    axi_wr(QD_H_PINS, 32'h2, r);
    wr(4'h6, 16'h8001);
    chk("latch1 on pin", latch[1], 16'h00aa);
    chk("latch2", latch[2], 16'h8001);
    chk("ladder2", ladder[2], 16'h8001 ^ QD_BIP_FLIP);
    chk("ladder0", ladder[0], 16'h1234);
    chk("uni", uni, 4'b0011);
    pa <= 1'b0;
    pb <= 1'b1;
    repeat (6) @(posedge clk);
    chk("uni swap", uni, 4'b1100);
    chk("ladder0 bip", ladder[0], 16'h1234 ^ QD_BIP_FLIP);
    chk("ladder2 uni", ladder[2], 16'h8001);
    $display("individual update test done");
  endtask : t_indiv

  task t_cal;
    logic [31:0] d;
    logic [1:0] r;
    frame(24'h840000);
    frame(24'h840000);
    axi_rd(QD_H_RXD, d, r);
    chk("readback", d, 32'h00041234);
    wr(4'h0, 16'h0014);
    chk("gain bits", gx4, 4'h5);
    wr(4'h8, 16'h0100);
    chk("zero0", zc[0], 9'h100);
    wr(4'hd, 16'h007f);
    chk("gain1", gc[1], 8'h7f);
    wr(4'h0, 16'h003c);
    $display("readback and calibration test done");
  endtask : t_cal

  task t_mon;
    int k;
    for (k = 0; k < 5; k++) begin
      wr(4'h1, 16'h0800 << k);
      chk("mon sel", msel, 5'h10 >> k);
    end
    wr(4'h1, 16'h9000);
    chk("mon two", msel, 5'h08);
    wr(4'h1, 16'h0000);
    chk("mon off", hiz, 1'b1);
    $display("monitor test done");
  endtask : t_mon

  task t_pd;
    int n;
    wr(4'h0, 16'h103c);
    chk("pd a", pd, 2'b01);
    wr(4'h5, 16'h0055);
    chk("latch1 in pd", latch[1], 16'h0055);
    wr(4'h0, 16'h003c);
    for (n = 0; n < 2000; n++) begin
      if (rdy[0] === 1'b1) break;
      @(posedge clk);
    end
    if (n == 2000) tmo();
    chk("wake time", wake_n >= QD_WAKE_CYC - 2 && wake_n <= QD_WAKE_CYC + 2, 1'b1);
    $display("power-down test done");
  endtask : t_pd

  task t_rst;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(QD_H_PINS, 32'h0, r);
    repeat (6) @(posedge clk);
    chk("pin rst latch", latch[2], 16'h0);
    chk("pin rst gain", gx4, QD_GAIN_RST);
    wr(4'h4, 16'h5555);
    chk("pin rst ignore", latch[0], 16'h0);
    axi_wr(QD_H_PINS, 32'h2, r);
    wr(4'h4, 16'h4321);
    chk("resume", latch[0], 16'h4321);
    chk("held zero", latch[3], 16'h0);
    wr(4'h0, 16'h2014);
    chk("sw rst gain", gx4, QD_GAIN_RST);
    chk("sw rst latch", latch[0], 16'h0);
    frame(24'h840000);
    frame(24'h840000);
    axi_rd(QD_H_RXD, d, r);
    chk("sw rst input", d, 32'h00040000);
    $display("reset test done");
  endtask : t_rst

  task t_framing;
    bang(32'h00040123, 23);
    chk("short frame", latch_b[0], 16'h0);
    bang(32'h03_04abcd, 26);
    chk("long frame", latch_b[0], 16'habcd);
    link_b.reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    bang(32'h00050777, 24);
    chk("ignored in rst", latch_b[1], 16'h0);
    chk("cleared in rst", latch_b[0], 16'h0);
    link_b.reset_pin_n <= 1'b1;
    $display("framing test done");
  endtask : t_framing

  initial begin
    link_b.sclk = 1'b1;
    link_b.cs_n = 1'b1;
    link_b.sdi = 1'b0;
    link_b.load_strobe_n = 1'b0;
    link_b.reset_pin_n = 1'b1;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_defer();
    t_indiv();
    t_cal();
    t_mon();
    t_pd();
    t_rst();
    t_framing();
    finish_test();
  end
endmodule : test_quad_dac_update_control
